// ==== verilog/vfd_pkg.sv ====
`default_nettype none
package vfd_pkg;
    // ************************************************************
    // Command decode bit positions
    // ************************************************************
    localparam int CMD_TEXT_ADDR_BIT = 7;
    localparam int CMD_GLYPH_ADDR_BIT = 6;
    localparam int CMD_FUNC_BIT = 5;
    localparam int CMD_SHIFT_BIT = 4;
    localparam int CMD_CTRL_BIT = 3;
    localparam int CMD_ENTRY_BIT = 2;
    localparam int ENTRY_INC_BIT = 1;
    localparam int ENTRY_SHIFT_BIT = 0;
    localparam int CTRL_DISP_BIT = 2;
    localparam int CTRL_CURSOR_BIT = 1;
    localparam int CTRL_BLINK_BIT = 0;
    localparam int SHIFT_TARGET_BIT = 3;
    localparam int SHIFT_DIR_BIT = 2;
    localparam int FUNC_BUS8_BIT = 4;
    localparam int GLYPH_DOT_BITS = 5;

    // ************************************************************
    // Address ranges, reset values and blink timing
    // ************************************************************
    localparam logic [6:0] TEXT_L1_FIRST = 7'h00;
    localparam logic [6:0] TEXT_L1_LAST = 7'h27;
    localparam logic [6:0] TEXT_L2_FIRST = 7'h40;
    localparam logic [6:0] TEXT_L2_LAST = 7'h67;
    localparam logic [5:0] SHIFT_LAST = 6'h27;
    localparam logic [5:0] GLYPH_LAST = 6'h3f;
    localparam logic [1:0] BRIGHT_FULL = 2'h0;
    localparam int CLK_HZ = 50_000_000;
    localparam int BLINK_HALF_MS = 500;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_ENTRY = 3'b001,
        CMD_CTRL = 3'b010,
        CMD_SHIFT = 3'b011,
        CMD_FUNC = 3'b100,
        CMD_GLYPH_ADDR = 3'b101,
        CMD_TEXT_ADDR = 3'b110
    } cmd_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic reg_select;
        logic [7:0] data;
    } host_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } host_rsp_t;

    typedef struct packed {
        logic display_on;
        logic cursor_on;
        logic blink_en;
        logic cursor_all_lit;
        logic converter_inhibit;
        logic bus_8bit;
        logic brightness_hi;
        logic brightness_lo;
        logic glyph_sel;
        logic [6:0] addr_counter;
        logic [5:0] text_shift;
    } disp_state_t;
endpackage : vfd_pkg
`default_nettype wire

// ==== verilog/vfd_instruction_decoder.sv ====
`timescale 1ns/1ns
`default_nettype none
module vfd_instruction_decoder #(
    parameter int BLINK_HALF_CYCLES = vfd_pkg::BLINK_HALF_MS * (vfd_pkg::CLK_HZ / 1000)
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Host transfers
    input wire vfd_pkg::host_req_t host_req,
    output vfd_pkg::host_rsp_t host_rsp,
    // Display state
    output vfd_pkg::disp_state_t disp_state,
    // Refresh scan ports
    input wire logic [6:0] text_scan_addr,
    output logic [7:0] text_scan_char,
    input wire logic [5:0] glyph_scan_addr,
    output logic [4:0] glyph_dots
);
    import vfd_pkg::*;

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Classifies an instruction by its leading one; lower bits are don't care
    function automatic cmd_t cmd_decode(input logic [7:0] b);
        cmd_t c;
        c = CMD_NONE;
        if (b[CMD_TEXT_ADDR_BIT]) begin
            c = CMD_TEXT_ADDR;
        end else if (b[CMD_GLYPH_ADDR_BIT]) begin
            c = CMD_GLYPH_ADDR;
        end else if (b[CMD_FUNC_BIT]) begin
            c = CMD_FUNC;
        end else if (b[CMD_SHIFT_BIT]) begin
            c = CMD_SHIFT;
        end else if (b[CMD_CTRL_BIT]) begin
            c = CMD_CTRL;
        end else if (b[CMD_ENTRY_BIT]) begin
            c = CMD_ENTRY;
        end
        return c;
    endfunction : cmd_decode
    // Steps the counter; text space skips from line end to the next line start
    function automatic logic [6:0] step_addr(input logic [6:0] a, input logic glyph,
                                             input logic inc);
        logic [6:0] n;
        n = inc ? a + 7'h01 : a - 7'h01;
        if (glyph) begin
            n = {1'b0, n[5:0]};
        end else if (inc && a == TEXT_L1_LAST) begin
            n = TEXT_L2_FIRST;
        end else if (inc && a == TEXT_L2_LAST) begin
            n = TEXT_L1_FIRST;
        end else if (!inc && a == TEXT_L2_FIRST) begin
            n = TEXT_L1_LAST;
        end else if (!inc && a == TEXT_L1_FIRST) begin
            n = TEXT_L2_LAST;
        end
        return n;
    endfunction : step_addr
    // Display offset in characters, counted modulo the line length
    function automatic logic [5:0] step_shift(input logic [5:0] s, input logic left);
        logic [5:0] n;
        if (left) begin
            n = (s == SHIFT_LAST) ? 6'h00 : s + 6'h01;
        end else begin
            n = (s == 6'h00) ? SHIFT_LAST : s - 6'h01;
        end
        return n;
    endfunction : step_shift

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0] text_ram [0:127];
    logic [7:0] glyph_ram [0:63];
    logic [6:0] ac;
    logic glyph_sel;
    logic inc_mode;
    logic shift_mode;
    logic display_on;
    logic cursor_on;
    logic blink_en;
    logic bus_8bit;
    logic [1:0] brightness;
    logic fs_pending;
    logic [5:0] text_shift;
    logic nib_phase;
    logic [3:0] nib_hold;
    logic [3:0] rd_low_hold;
    logic [$clog2(BLINK_HALF_CYCLES + 1) - 1:0] blink_cnt;
    logic blink_phase;

    // ************************************************************
    // Byte assembly
    // ************************************************************
    logic strobe;
    logic byte_done;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic is_cmd;
    logic is_data_wr;
    logic is_data_rd;
    cmd_t cmd;

    // A byte completes at once on 8 bits, or on the second nibble
    assign strobe = host_req.wr | host_req.rd;
    assign byte_done = strobe & (bus_8bit | nib_phase);
    assign wbyte = bus_8bit ? host_req.data : {nib_hold, host_req.data[7:4]};
    assign is_cmd = byte_done & host_req.wr & ~host_req.reg_select;
    assign is_data_wr = byte_done & host_req.wr & host_req.reg_select & ~fs_pending;
    assign is_data_rd = byte_done & host_req.rd & host_req.reg_select;
    assign cmd = is_cmd ? cmd_decode(wbyte) : CMD_NONE;
    // Read source follows the space of the last address command
    always_comb begin
        if (!host_req.reg_select) begin
            rbyte = {1'b0, ac};
        end else if (glyph_sel) begin
            rbyte = glyph_ram[ac[5:0]];
        end else begin
            rbyte = text_ram[ac];
        end
    end
    // Nibble phase and upper nibble latch
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            nib_phase <= 1'b0;
            nib_hold <= 4'h0;
        end else if (bus_8bit) begin
            nib_phase <= 1'b0;
        end else if (strobe) begin
            nib_phase <= ~nib_phase;
            nib_hold <= host_req.data[7:4];
        end
    end
    // Read answer, upper nibble first in 4-bit mode
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            host_rsp <= '0;
            rd_low_hold <= 4'h0;
        end else begin
            host_rsp.valid <= host_req.rd;
            if (host_req.rd && bus_8bit) begin
                host_rsp.data <= rbyte;
            end else if (host_req.rd && !nib_phase) begin
                host_rsp.data <= {rbyte[7:4], 4'h0};
                rd_low_hold <= rbyte[3:0];
            end else if (host_req.rd) begin
                host_rsp.data <= {rd_low_hold, 4'h0};
            end
        end
    end

    // ************************************************************
    // Mode registers
    // ************************************************************
    // Entry mode, display control and bus width
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            inc_mode <= 1'b1;
            shift_mode <= 1'b0;
            display_on <= 1'b0;
            cursor_on <= 1'b0;
            blink_en <= 1'b0;
            bus_8bit <= 1'b1;
        end else begin
            case (cmd)
                CMD_ENTRY: begin
                    inc_mode <= wbyte[ENTRY_INC_BIT];
                    shift_mode <= wbyte[ENTRY_SHIFT_BIT];
                end
                CMD_CTRL: begin
                    display_on <= wbyte[CTRL_DISP_BIT];
                    cursor_on <= wbyte[CTRL_CURSOR_BIT];
                    blink_en <= wbyte[CTRL_BLINK_BIT];
                end
                CMD_FUNC: begin
                    bus_8bit <= wbyte[FUNC_BUS8_BIT];
                end
                default: begin
                end
            endcase
        end
    end
    // Brightness byte armed by function set
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fs_pending <= 1'b0;
            brightness <= BRIGHT_FULL;
        end else if (cmd == CMD_FUNC) begin
            fs_pending <= 1'b1;
        end else if (byte_done && host_req.wr) begin
            fs_pending <= 1'b0;
            if (host_req.reg_select && fs_pending) begin
                brightness <= wbyte[1:0];
            end
        end
    end

    // ************************************************************
    // Address counter and display shift
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ac <= TEXT_L1_FIRST;
            glyph_sel <= 1'b0;
        end else if (cmd == CMD_TEXT_ADDR) begin
            ac <= wbyte[6:0];
            glyph_sel <= 1'b0;
        end else if (cmd == CMD_GLYPH_ADDR) begin
            ac <= {1'b0, wbyte[5:0]};
            glyph_sel <= 1'b1;
        end else if (cmd == CMD_SHIFT) begin
            ac <= step_addr(ac, glyph_sel, wbyte[SHIFT_DIR_BIT]);
        end else if (is_data_wr || is_data_rd) begin
            ac <= step_addr(ac, glyph_sel, inc_mode);
        end
    end
    // Display shift; only text writes and shift commands move it
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            text_shift <= 6'h00;
        end else if (cmd == CMD_SHIFT && wbyte[SHIFT_TARGET_BIT]) begin
            text_shift <= step_shift(text_shift, ~wbyte[SHIFT_DIR_BIT]);
        end else if (is_data_wr && !glyph_sel && shift_mode) begin
            text_shift <= step_shift(text_shift, inc_mode);
        end
    end

    // ************************************************************
    // RAMs
    // ************************************************************
    // Full byte is stored; glyph dots drop the upper three bits on scan
    always_ff @(posedge clk_sys) begin
        if (is_data_wr && glyph_sel) begin
            glyph_ram[ac[5:0]] <= wbyte;
        end else if (is_data_wr) begin
            text_ram[ac] <= wbyte;
        end
    end
    // Refresh read ports
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            text_scan_char <= 8'h00;
            glyph_dots <= 5'h00;
        end else begin
            text_scan_char <= text_ram[text_scan_addr];
            glyph_dots <= glyph_ram[glyph_scan_addr][GLYPH_DOT_BITS - 1:0];
        end
    end

    // ************************************************************
    // Blink timer
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            blink_cnt <= '0;
            blink_phase <= 1'b0;
        end else if (!blink_en) begin
            blink_cnt <= '0;
            blink_phase <= 1'b0;
        end else if (blink_cnt == $bits(blink_cnt)'(BLINK_HALF_CYCLES - 1)) begin
            blink_cnt <= '0;
            blink_phase <= ~blink_phase;
        end else begin
            blink_cnt <= blink_cnt + 1'b1;
        end
    end

    // Registered status outputs
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            disp_state <= '0;
            disp_state.converter_inhibit <= 1'b1;
            disp_state.bus_8bit <= 1'b1;
        end else begin
            disp_state.display_on <= display_on;
            disp_state.cursor_on <= cursor_on;
            disp_state.blink_en <= blink_en;
            disp_state.cursor_all_lit <= blink_en & blink_phase;
            disp_state.converter_inhibit <= ~display_on;
            disp_state.bus_8bit <= bus_8bit;
            disp_state.brightness_hi <= brightness[1];
            disp_state.brightness_lo <= brightness[0];
            disp_state.glyph_sel <= glyph_sel;
            disp_state.addr_counter <= ac;
            disp_state.text_shift <= text_shift;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    property p_entry;
        cmd == CMD_ENTRY |=> {inc_mode, shift_mode} == $past(wbyte[ENTRY_INC_BIT:ENTRY_SHIFT_BIT]);
    endproperty
    a_entry: assert property (p_entry) else $error("entry mode not taken");
    property p_glyph_wrap;
        is_data_wr && glyph_sel && inc_mode && ac == {1'b0, GLYPH_LAST} |=> ac == '0;
    endproperty
    a_glyph_wrap: assert property (p_glyph_wrap) else $error("glyph wrap wrong");
    property p_write_shift;
        is_data_wr && !glyph_sel && shift_mode && inc_mode
            |=> text_shift == step_shift($past(text_shift), 1'b1);
    endproperty
    a_write_shift: assert property (p_write_shift) else $error("no display shift");
    property p_read_no_shift;
        is_data_rd && cmd == CMD_NONE |=> $stable(text_shift);
    endproperty
    a_read_no_shift: assert property (p_read_no_shift) else $error("read shifted");
    property p_inhibit;
        cmd == CMD_CTRL && !wbyte[CTRL_DISP_BIT] |=> ##1 disp_state.converter_inhibit;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("converter not inhibited");
    property p_bright;
        byte_done && host_req.wr && host_req.reg_select && fs_pending
            |=> brightness == $past(wbyte[1:0]) && !fs_pending;
    endproperty
    a_bright: assert property (p_bright) else $error("brightness not taken");
    property p_bright_cancel;
        is_cmd && fs_pending && cmd != CMD_FUNC |=> !fs_pending && $stable(brightness);
    endproperty
    a_bright_cancel: assert property (p_bright_cancel) else $error("cancel failed");
    property p_glyph_load;
        cmd == CMD_GLYPH_ADDR |=> glyph_sel && ac == {1'b0, $past(wbyte[5:0])};
    endproperty
    a_glyph_load: assert property (p_glyph_load) else $error("glyph load wrong");
    property p_nibble;
        !bus_8bit && strobe && !nib_phase |=> nib_phase && $stable(ac);
    endproperty
    a_nibble: assert property (p_nibble) else $error("nibble completed byte");
    c_shift_cmd: cover property (cmd == CMD_SHIFT ##[1:8] cmd == CMD_SHIFT);
    c_bright: cover property (fs_pending && byte_done && host_req.wr && host_req.reg_select);
    c_nibble_rd: cover property (!bus_8bit && is_data_rd);
    c_blink: cover property (blink_en && $rose(blink_phase));
endmodule : vfd_instruction_decoder
`default_nettype wire

// ==== dv/vfd_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// Host processor issuing byte or nibble transfers
// ************************************************************
module vfd_host_model (
    // Clock
    input wire logic clk_sys,
    // Transfers to the decoder
    output var vfd_pkg::host_req_t host_req,
    // Answers from the decoder
    input wire vfd_pkg::host_rsp_t host_rsp
);
    import vfd_pkg::*;
    logic nib_mode = 1'b0; // 4-bit bus in use
    int rsp_wait = 0; // Cycles waited for the last read answer

    // Idle bus at time zero
    initial begin
        host_req = '0;
    end

    // One strobe held across one sampling edge; released lines show inverted data
    task automatic strobe(input logic rs, input logic rd, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        host_req = '{wr: ~rd, rd: rd, reg_select: rs, data: d};
        @(posedge clk_sys);
        #1;
        host_req = '{wr: 1'b0, rd: 1'b0, reg_select: ~rs, data: ~d};
    endtask : strobe

    // Byte write, split into nibbles on a 4-bit bus
    task automatic send(input logic rs, input logic [7:0] b);
        if (nib_mode) begin
            strobe(rs, 1'b0, {b[7:4], 4'h0});
            strobe(rs, 1'b0, {b[3:0], 4'h0});
        end else begin
            strobe(rs, 1'b0, b);
        end
        if (!rs && b[7:5] == 3'b001) begin
            nib_mode = ~b[4];
        end
    endtask : send

    // One read strobe and its answer, bounded wait
    task automatic grab(input logic rs, output logic [7:0] v);
        int n;
        n = 0;
        strobe(rs, 1'b1, 8'h00);
        while (host_rsp.valid !== 1'b1 && n < 4) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        rsp_wait = n;
        v = host_rsp.data;
    endtask : grab

    // Byte read, upper nibble first on a 4-bit bus
    task automatic fetch(input logic rs, output logic [7:0] v);
        logic [7:0] hi;
        grab(rs, hi);
        if (nib_mode) begin
            grab(rs, v);
            v = {hi[7:4], v[7:4]};
        end else begin
            v = hi;
        end
    endtask : fetch
endmodule : vfd_host_model
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// Decoder bench: random bytes with corner cases
// ************************************************************
module tb;
    import vfd_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    host_req_t host_req;
    host_rsp_t host_rsp;
    disp_state_t ds;
    logic [6:0] t_addr = 7'h00;
    logic [7:0] t_char;
    logic [5:0] g_addr = 6'h00;
    logic [4:0] dots;
    logic [7:0] ram [128];
    logic [7:0] v;
    logic [7:0] g0;
    logic [7:0] g1;
    logic [6:0] ac;
    int sh;
    int n;
    int failures = 0;
    int n_tests = 0;

    vfd_instruction_decoder #(.BLINK_HALF_CYCLES(8)) i_vfd_instruction_decoder (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .host_req(host_req), .host_rsp(host_rsp),
        .disp_state(ds), .text_scan_addr(t_addr), .text_scan_char(t_char),
        .glyph_scan_addr(g_addr), .glyph_dots(dots));
    vfd_host_model i_vfd_host_model (.clk_sys(clk_sys), .host_req(host_req),
        .host_rsp(host_rsp));

    // 50 MHz clock
    always #10 clk_sys = ~clk_sys;

    // Helpers for waiting, transfers and comparing
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : settle
    task automatic wr(input logic rs, input logic [7:0] b);
        i_vfd_host_model.send(rs, b);
    endtask : wr
    task automatic rd(output logic [7:0] b);
        i_vfd_host_model.fetch(1'b1, b);
        chk(8'(i_vfd_host_model.rsp_wait), 8'h00);
    endtask : rd
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // Expected text counter step, skipping the gap between lines
    function automatic logic [6:0] step_text(input logic [6:0] a, input logic inc);
        if (inc) begin
            return (a == 7'h27) ? 7'h40 : (a == 7'h67) ? 7'h00 : a + 7'h01;
        end
        return (a == 7'h40) ? 7'h27 : (a == 7'h00) ? 7'h67 : a - 7'h01;
    endfunction : step_text

    // Watchdog on a hung run
    initial begin
        #400000;
        failures++;
        give_verdict();
    end

    // Main sequence
    initial begin
        void'($urandom(32'hde9c76c6));
        repeat (5) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        chk(8'(ds.converter_inhibit), 8'h01);
        chk(8'({ds.brightness_hi, ds.brightness_lo}), 8'h00);
        for (int b = 0; b < 4; b++) begin
            wr(1'b0, 8'(8'h30 + $urandom_range(15)));
            wr(1'b1, {6'($urandom), 2'(b)});
            settle();
            chk(8'({ds.brightness_hi, ds.brightness_lo}), 8'(b));
        end
        wr(1'b0, 8'h30);
        wr(1'b0, 8'h06);
        wr(1'b1, 8'h00);
        settle();
        chk(8'({ds.brightness_hi, ds.brightness_lo}), 8'h03);
        for (int c = 8; c < 16; c++) begin
            wr(1'b0, 8'(c));
            settle();
            chk(8'({ds.display_on, ds.cursor_on, ds.blink_en}), 8'(c & 7));
            chk(8'(ds.converter_inhibit), 8'(((c >> 2) & 1) ^ 1));
        end
        n = 0;
        v[0] = ds.cursor_all_lit;
        while (ds.cursor_all_lit === v[0] && n < 40) begin
            tick();
            n++;
        end
        v[0] = ds.cursor_all_lit;
        n = 0;
        while (ds.cursor_all_lit === v[0] && n < 40) begin
            tick();
            n++;
        end
        chk(8'(n), 8'h08);
        // Text space across the line boundary, write then read back
        wr(1'b0, 8'ha6);
        ac = 7'h26;
        for (int i = 0; i < 4; i++) begin
            ram[ac] = 8'($urandom);
            wr(1'b1, ram[ac]);
            ac = step_text(ac, 1'b1);
        end
        t_addr = 7'h40;
        settle();
        chk(8'(ds.addr_counter), 8'(ac));
        chk(t_char, ram[7'h40]);
        i_vfd_host_model.fetch(1'b0, v);
        chk(v, {1'b0, ac});
        wr(1'b0, 8'ha6);
        ac = 7'h26;
        for (int i = 0; i < 4; i++) begin
            rd(v);
            chk(v, ram[ac]);
            ac = step_text(ac, 1'b1);
        end
        wr(1'b0, 8'h04);
        wr(1'b0, 8'hc0);
        wr(1'b1, 8'($urandom));
        settle();
        chk(8'(ds.addr_counter), 8'h27);
        // Glyph space wrap and hidden upper bits
        wr(1'b0, 8'h06);
        wr(1'b0, 8'h7f);
        g0 = 8'($urandom);
        g1 = 8'($urandom);
        wr(1'b1, g0);
        wr(1'b1, g1);
        g_addr = 6'h3f;
        settle();
        chk(8'({ds.glyph_sel, ds.addr_counter}), 8'h81);
        chk(8'(dots), 8'(g0[4:0]));
        wr(1'b0, 8'h7f);
        rd(v);
        chk(v, g0);
        wr(1'b0, 8'h04);
        wr(1'b0, 8'h40);
        rd(v);
        settle();
        chk(v, g1);
        chk(8'(ds.addr_counter), 8'h3f);
        // Shift on access: writes shift, reads and glyph accesses do not
        wr(1'b0, 8'h07);
        wr(1'b0, 8'h90);
        wr(1'b1, 8'($urandom));
        settle();
        chk(8'(ds.text_shift), 8'h01);
        wr(1'b0, 8'h90);
        rd(v);
        wr(1'b0, 8'h40);
        wr(1'b1, 8'($urandom));
        settle();
        chk(8'(ds.text_shift), 8'h01);
        wr(1'b0, 8'h05);
        wr(1'b0, 8'h90);
        wr(1'b1, 8'($urandom));
        settle();
        chk(8'(ds.text_shift), 8'h00);
        // Every shift command code, don't-care bits included
        wr(1'b0, 8'h06);
        wr(1'b0, 8'h90);
        ac = 7'h10;
        sh = 0;
        for (int c = 0; c < 16; c++) begin
            wr(1'b0, 8'(8'h10 + c));
            ac = c[2] ? ac + 7'h01 : ac - 7'h01;
            if (c[3]) begin
                sh = c[2] ? (sh + 39) % 40 : (sh + 1) % 40;
            end
            settle();
            chk(8'(ds.addr_counter), 8'(ac));
            chk(8'(ds.text_shift), 8'(sh));
        end
        // Nibble bus round trip, then back to bytes
        wr(1'b0, 8'h2a);
        settle();
        chk(8'(ds.bus_8bit), 8'h00);
        wr(1'b0, 8'h85);
        g0 = 8'($urandom);
        wr(1'b1, g0);
        wr(1'b0, 8'h85);
        rd(v);
        settle();
        chk(v, g0);
        chk(8'(ds.addr_counter), 8'h06);
        wr(1'b0, 8'h30);
        settle();
        chk(8'(ds.bus_8bit), 8'h01);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
